// *** hw/ptp_evt_ctl.sv ***
// Top: APB registers, trigger pulse width generator, cascade period store, timestamp units
// Function
// - In cascade mode next trigger time is target time plus loop period
// - Loop period register is selected by two-bit trigger unit index
// - Output pulse high width is pulse width times 8 ns, rounded up to whole 5 ns cycles
// - PPS width uses high byte above the 16-bit pulse width
// - Each input unit reports its detected enabled edge count, up to 15
// - Count saturates at 15 and overflow bit is set
// - In cascade mode only the chain tail among joined units sets its overflow flag
// - Rising edges are captured only while rise enable is set
// - Falling edges are captured only while fall enable is set
// - Chain last unit bit marks the final unit of the chain
// - Upstream done is taken from unit 1 or unit 0 by select bit
// - Chain join enable includes the unit in the cascade chain
// - Successive captures of one unit stay distinct
// - The first capture after a clear records edge polarity, 1 rising, 0 falling
`timescale 1ns/1ps
module ptp_evt_ctl
  import ptp_evt_pkg::*;
#(
  parameter int NTRIG = NUM_TRIG
)
(
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic [NUM_TS-1:0] TS_PIN,
  input  wire logic [31:0]       TRIG_TARGET,
  output logic      [31:0]       TRIG_NEXT,
  output logic                   TRIG_OUT,
  output logic                   IRQ
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [0:0] { PW_IDLE, PW_HIGH } pw_state_t;

  typedef struct packed {
    logic [NTRIG-1:0][31:0] loop_period;
    logic [1:0]             trig_idx;
    logic                   ts_idx;
    logic [15:0]            pulse_width;
    logic [7:0]             pps_high;
    logic                   pps_mode;
    logic                   cascade;
    logic [NUM_TS-1:0][4:0] ts_cfg;
    logic [2:0]             irq_stat;
    logic [2:0]             irq_mask;
    pw_state_t              pw_state;
    logic [36:0]            pw_left_ps;
    logic                   trig_out;
    logic [31:0]            trig_next;
    logic [31:0]            prdata;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  ts_unit_t [NUM_TS-1:0] ts_cfg_w;
  ts_unit_t [NUM_TS-1:0] ts_stat_w;
  logic     [NUM_TS-1:0] ts_evt_w;
  logic     [NUM_TS-1:0] ts_ovf_w;
  logic     [NUM_TS-1:0] ts_clr_w;
  logic     [NUM_TS-1:0] ts_up_w;

  function automatic logic is_acc(input logic [11:0] a, input logic [11:0] off);
    is_acc = PSEL && PENABLE && (a == off);
  endfunction

  function automatic logic [31:0] ts_word(input ts_unit_t u);
    ts_word                = 32'h0000_0000;
    ts_word[CNT_LSB+:4]    = u.captured_event_count;
    ts_word[OVF_BIT]       = u.captured_event_overflow;
    ts_word[RISE_BIT]      = u.rise_capture_en;
    ts_word[FALL_BIT]      = u.fall_capture_en;
    ts_word[LAST_BIT]      = u.chain_last_unit;
    ts_word[UPSEL_BIT]     = u.upstream_done_sel;
    ts_word[JOIN_BIT]      = u.chain_join_en;
  endfunction

  // ---------------------------------------------------------------
  // Timestamp units
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_TS; g++) begin : g_ts
      always_comb begin
        ts_cfg_w[g]                   = '0;
        ts_cfg_w[g].rise_capture_en   = st_r.ts_cfg[g][4];
        ts_cfg_w[g].fall_capture_en   = st_r.ts_cfg[g][3];
        ts_cfg_w[g].chain_last_unit   = st_r.ts_cfg[g][2];
        ts_cfg_w[g].upstream_done_sel = st_r.ts_cfg[g][1];
        ts_cfg_w[g].chain_join_en     = st_r.ts_cfg[g][0];
        // Head unit (select 0 on unit 0) sees no upstream and is always armed
        if (st_r.ts_cfg[g][1]) begin
          ts_up_w[g] = ts_stat_w[1].done;
        end else begin
          ts_up_w[g] = (g == 0) ? 1'b1 : ts_stat_w[0].done;
        end
        ts_clr_w[g] = is_acc(PADDR, OFF_TS_STATUS) && PWRITE && (st_r.ts_idx == 1'(g));
      end
      ts_edge_unit u_ts (
        .clk           (CLOCK),
        .rst_n         (RST_N),
        .pin_in        (TS_PIN[g]),
        .cascade_mode  (st_r.cascade),
        .upstream_done (ts_up_w[g]),
        .clear         (ts_clr_w[g]),
        .cfg           (ts_cfg_w[g]),
        .stat          (ts_stat_w[g]),
        .event_pulse   (ts_evt_w[g]),
        .ovf_pulse     (ts_ovf_w[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic        wr;
  logic        rd;
  logic        trig_start;
  logic [36:0] width_ps;
  logic [2:0]  irq_set;
  ts_unit_t    ts_sel;

  always_comb begin
    st_nxt     = st_r;
    wr         = PSEL && PENABLE && PWRITE;
    rd         = PSEL && !PENABLE && !PWRITE;
    trig_start = 1'b0;
    ts_sel     = ts_stat_w[st_r.ts_idx];
    irq_set    = 3'b000;

    // Register writes
    if (wr) begin
      case (PADDR)
        OFF_UNIT_INDEX: begin
          st_nxt.trig_idx = PWDATA[TRIG_IDX_LSB+:2];
          st_nxt.ts_idx   = PWDATA[TS_IDX_BIT];
        end
        OFF_CASCADE_LOOP: st_nxt.loop_period[st_r.trig_idx] = PWDATA;
        OFF_PULSE_WIDTH: begin
          st_nxt.pulse_width = PWDATA[15:0];
          st_nxt.pps_high    = PWDATA[PPS_LSB+:8];
        end
        OFF_TS_STATUS: begin
          st_nxt.ts_cfg[st_r.ts_idx] = {PWDATA[RISE_BIT], PWDATA[FALL_BIT], PWDATA[LAST_BIT],
                                        PWDATA[UPSEL_BIT], PWDATA[JOIN_BIT]};
        end
        OFF_MODE_CTL: begin
          trig_start      = PWDATA[TRIG_START_BIT];
          st_nxt.pps_mode = PWDATA[TRIG_PPS_BIT];
          st_nxt.cascade  = PWDATA[CASCADE_BIT];
        end
        OFF_IRQ_STATUS: st_nxt.irq_stat = st_r.irq_stat & ~PWDATA[2:0];
        OFF_IRQ_MASK:   st_nxt.irq_mask = PWDATA[2:0];
        default: ;
      endcase
    end

    // Pulse generator; width kept in ps since 8 ns steps do not divide 5 ns cycles
    // Mode bits written together with the start apply to this very pulse
    if (st_nxt.pps_mode) begin
      width_ps = 37'({st_r.pps_high, st_r.pulse_width}) * 37'(WIDTH_UNIT_PS);
    end else begin
      width_ps = 37'(st_r.pulse_width) * 37'(WIDTH_UNIT_PS);
    end
    case (st_r.pw_state)
      PW_IDLE: begin
        if (trig_start && width_ps != 37'd0) begin
          st_nxt.pw_state   = PW_HIGH;
          st_nxt.pw_left_ps = width_ps;
          st_nxt.trig_out   = 1'b1;
          // Cascade: next target is the current one plus the loop period
          st_nxt.trig_next  = st_nxt.cascade ? TRIG_TARGET + st_r.loop_period[st_r.trig_idx]
                                           : TRIG_TARGET;
        end
      end
      PW_HIGH: begin
        if (st_r.pw_left_ps <= 37'(CLK_PERIOD_PS)) begin
          st_nxt.pw_state = PW_IDLE;
          st_nxt.trig_out = 1'b0;
          irq_set[IRQ_TRIG_BIT] = 1'b1;
        end else begin
          st_nxt.pw_left_ps = st_r.pw_left_ps - 37'(CLK_PERIOD_PS);
        end
      end
      default: st_nxt.pw_state = PW_IDLE;
    endcase

    // Sticky events: a set in the same cycle as a clear wins
    irq_set[IRQ_EVT_BIT] = |ts_evt_w;
    irq_set[IRQ_OVF_BIT] = |ts_ovf_w;
    st_nxt.irq_stat      = st_nxt.irq_stat | irq_set;

    // Read data, registered at the setup edge so it stands through the access phase
    if (rd) begin
      case (PADDR)
        OFF_UNIT_INDEX:   st_nxt.prdata = {23'h0, st_r.ts_idx, 6'h0, st_r.trig_idx};
        OFF_CASCADE_LOOP: st_nxt.prdata = st_r.loop_period[st_r.trig_idx];
        OFF_PULSE_WIDTH:  st_nxt.prdata = {8'h00, st_r.pps_high, st_r.pulse_width};
        OFF_TS_STATUS:    st_nxt.prdata = ts_word(ts_sel);
        OFF_TS_SAMPLE:    st_nxt.prdata = {1'b0, ts_sel.first_sample_polarity, 30'h0};
        OFF_MODE_CTL:     st_nxt.prdata = {29'h0, st_r.cascade, st_r.pps_mode, st_r.trig_out};
        OFF_IRQ_STATUS:   st_nxt.prdata = {29'h0, st_r.irq_stat};
        OFF_IRQ_MASK:     st_nxt.prdata = {29'h0, st_r.irq_mask};
        default:          st_nxt.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_r             <= '0;
      st_r.pulse_width <= RST_PULSE_WIDTH;
      st_r.pps_high    <= RST_PPS_HIGH;
      st_r.pw_state    <= PW_IDLE;
      for (int i = 0; i < NTRIG; i++) begin
        st_r.loop_period[i] <= RST_CASCADE_LOOP;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Zero wait state slave; unmapped addresses read zero and do not error
  assign PREADY    = 1'b1;
  assign PSLVERR   = 1'b0;
  assign PRDATA    = st_r.prdata;
  assign TRIG_OUT  = st_r.trig_out;
  assign TRIG_NEXT = st_r.trig_next;
  assign IRQ       = |(st_r.irq_stat & st_r.irq_mask);

endmodule

// *** include/ptp_evt_pkg.sv ***
// Package: register map, field layout, reset values and types of the trigger/timestamp control block
package ptp_evt_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_UNIT_INDEX   = 12'h0_500;
  localparam logic [11:0] OFF_CASCADE_LOOP = 12'h0_544;
  localparam logic [11:0] OFF_PULSE_WIDTH  = 12'h0_548;
  localparam logic [11:0] OFF_TS_STATUS    = 12'h0_550;
  localparam logic [11:0] OFF_TS_SAMPLE    = 12'h0_554;
  localparam logic [11:0] OFF_MODE_CTL     = 12'h0_580;
  localparam logic [11:0] OFF_IRQ_STATUS   = 12'h0_584;
  localparam logic [11:0] OFF_IRQ_MASK     = 12'h0_588;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TRIG_IDX_LSB   = 0;
  localparam int TS_IDX_BIT     = 8;
  localparam int CNT_LSB        = 17;
  localparam int OVF_BIT        = 16;
  localparam int RISE_BIT       = 7;
  localparam int FALL_BIT       = 6;
  localparam int LAST_BIT       = 5;
  localparam int UPSEL_BIT      = 1;
  localparam int JOIN_BIT       = 0;
  localparam int POL_BIT        = 30;
  localparam int PPS_LSB        = 16;
  localparam int TRIG_START_BIT = 0;
  localparam int TRIG_PPS_BIT   = 1;
  localparam int CASCADE_BIT    = 2;
  localparam int IRQ_EVT_BIT    = 0;
  localparam int IRQ_OVF_BIT    = 1;
  localparam int IRQ_TRIG_BIT   = 2;

  // ---------------------------------------------------------------
  // Reset values and widths
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_CASCADE_LOOP = 32'h0000_0000;
  localparam logic [15:0] RST_PULSE_WIDTH  = 16'h0000;
  localparam logic [7:0]  RST_PPS_HIGH     = 8'h00;
  localparam logic [3:0]  CNT_MAX          = 4'hF;
  localparam int          NUM_TRIG         = 4;
  localparam int          NUM_TS           = 2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int WIDTH_UNIT_PS   = 8000;
  // 8 ns is not a whole number of 5 ns cycles: width counted in ps
  localparam int STEP_NS         = 1;
  localparam int CLK_PERIOD_NS   = CLK_PERIOD_PS / 1000;

  typedef struct packed {
    logic       rise_capture_en;
    logic       fall_capture_en;
    logic       chain_last_unit;
    logic       upstream_done_sel;
    logic       chain_join_en;
    logic [3:0] captured_event_count;
    logic       captured_event_overflow;
    logic       first_sample_polarity;
    logic       done;
  } ts_unit_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// *** hw/ts_edge_unit.sv ***
// One timestamp input unit: edge detect, event count, overflow and chaining
`timescale 1ns/1ps
module ts_edge_unit
  import ptp_evt_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire logic     pin_in,
  input  wire logic     cascade_mode,
  input  wire logic     upstream_done,
  input  wire logic     clear,
  input  wire ts_unit_t cfg,
  output ts_unit_t      stat,
  output logic          event_pulse,
  output logic          ovf_pulse
);

  typedef struct packed {
    logic       pin_d;
    logic [3:0] cnt;
    logic       ovf;
    logic       pol;
    logic       done;
  } st_t;

  st_t st_r;
  st_t st_nxt;
  logic rise;
  logic fall;
  logic hit;
  logic armed;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.pin_d = pin_in;
    // Single-cycle edge detection at 200 MHz resolves inputs well beyond 25 MHz
    rise        = pin_in & ~st_r.pin_d & cfg.rise_capture_en;
    fall        = ~pin_in & st_r.pin_d & cfg.fall_capture_en;
    // A chained unit waits until its upstream unit reports done
    armed       = !(cascade_mode && cfg.chain_join_en) || upstream_done;
    hit         = (rise | fall) & armed;
    ovf_pulse   = 1'b0;
    if (clear) begin
      st_nxt.cnt  = 4'h0;
      st_nxt.ovf  = 1'b0;
      st_nxt.done = 1'b0;
    end
    if (hit) begin
      // A clear in the same cycle restarts the count, so no overflow then
      if (st_r.cnt == CNT_MAX && !clear) begin
        // Saturate; in a chain only the tail flags the overflow
        if (!(cascade_mode && cfg.chain_join_en) || cfg.chain_last_unit) begin
          st_nxt.ovf = 1'b1;
          ovf_pulse  = 1'b1;
        end
        st_nxt.cnt  = CNT_MAX;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
      if (st_r.cnt == 4'h0 || clear) begin
        st_nxt.pol = rise;
      end
      if (clear) begin
        st_nxt.cnt = 4'h1;
      end
    end
    event_pulse = hit;
    stat                        = cfg;
    stat.captured_event_count    = st_r.cnt;
    stat.captured_event_overflow = st_r.ovf;
    stat.first_sample_polarity   = st_r.pol;
    stat.done                    = st_r.done;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// *** bench/ptp_evt_checker.sv ***
// Checker of register and trigger behaviour at the block ports
`timescale 1ns/1ps
module ptp_evt_checker
  import ptp_evt_pkg::*;
#(
  parameter int NTRIG = NUM_TRIG
)
(
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic [31:0] TRIG_TARGET,
  input wire logic [31:0] TRIG_NEXT,
  input wire logic        TRIG_OUT,
  input wire logic        IRQ
);
  // ----------------------------------------
  // Shadow of the registers written over APB
  // ----------------------------------------
  logic [31:0] per_r [NTRIG];
  logic [7:0]  cfg_r [2];
  logic [8:0]  idx_r;
  logic [23:0] pw_r;
  logic [2:0]  mode_r;
  logic [2:0]  mask_r;
  logic [31:0] nxt_r;
  logic [31:0] hi_r;
  wire logic        wr    = PSEL && PENABLE && PWRITE && PREADY;
  wire logic        rd    = PSEL && PENABLE && !PWRITE && PREADY;
  wire logic        start = wr && PADDR == OFF_MODE_CTL && PWDATA[TRIG_START_BIT];
  wire logic [7:0]  cfg   = cfg_r[idx_r[TS_IDX_BIT]];
  // Whole 5 ns cycles needed to cover the width in 8 ns steps
  wire logic [31:0] exp_w = (32'(pw_r[15:0]) * 8 + 4) / 5;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      per_r <= '{default: '0};
      cfg_r <= '{default: '0};
      {idx_r, pw_r, mode_r, mask_r, nxt_r, hi_r} <= '0;
    end else begin
      hi_r <= TRIG_OUT ? hi_r + 1 : '0;
      if (start) begin
        nxt_r <= PWDATA[CASCADE_BIT] ? TRIG_TARGET + per_r[idx_r[1:0]] : TRIG_TARGET;
      end
      if (wr) begin
        case (PADDR)
          OFF_UNIT_INDEX:   idx_r <= PWDATA[8:0];
          OFF_CASCADE_LOOP: per_r[idx_r[1:0]] <= PWDATA;
          OFF_PULSE_WIDTH:  pw_r <= PWDATA[23:0];
          OFF_TS_STATUS:    cfg_r[idx_r[TS_IDX_BIT]] <= PWDATA[7:0] & 8'hE3;
          OFF_MODE_CTL:     mode_r <= PWDATA[2:0];
          OFF_IRQ_MASK:     mask_r <= PWDATA[2:0];
          default:          ;
        endcase
      end
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  chk_pulse_width: assert property ($fell(TRIG_OUT) && !mode_r[TRIG_PPS_BIT] |-> hi_r == exp_w)
    else $error("trigger pulse width wrong");
  chk_next_time: assert property (start |-> ##[1:3] TRIG_NEXT == nxt_r)
    else $error("next trigger time wrong");
  chk_loop_read: assert property (rd && PADDR == OFF_CASCADE_LOOP |-> PRDATA == per_r[idx_r[1:0]])
    else $error("loop period readback wrong");
  chk_pps_read: assert property (rd && PADDR == OFF_PULSE_WIDTH |-> PRDATA == {8'h00, pw_r})
    else $error("pulse width readback wrong");
  chk_cfg_read: assert property (rd && PADDR == OFF_TS_STATUS |-> (PRDATA[7:0] & 8'hE3) == cfg)
    else $error("edge unit config readback wrong");
  chk_count_sat: assert property (rd && PADDR == OFF_TS_STATUS |-> !PRDATA[OVF_BIT] || PRDATA[20:17] == CNT_MAX)
    else $error("overflow without full count");
  chk_tail_only: assert property (rd && PADDR == OFF_TS_STATUS && mode_r[CASCADE_BIT] && cfg[JOIN_BIT]
                                  && !cfg[LAST_BIT] |-> !PRDATA[OVF_BIT])
    else $error("non-tail unit flagged overflow");
  chk_irq_mask: assert property (IRQ |-> mask_r != 3'h0)
    else $error("interrupt while fully masked");
  cover property (start);
  cover property ($fell(TRIG_OUT));
  cover property (IRQ);
endmodule
bind ptp_evt_ctl ptp_evt_checker #(.NTRIG(NTRIG)) u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .TRIG_TARGET(TRIG_TARGET), .TRIG_NEXT(TRIG_NEXT), .TRIG_OUT(TRIG_OUT), .IRQ(IRQ));

// *** bench/ts_pin_model.sv ***
// Board side model: event input pins and trigger output monitor
`timescale 1ns/1ps
module ts_pin_model
  import ptp_evt_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              TRIG_OUT,
  output logic      [NUM_TS-1:0] TS_PIN,
  output logic      [31:0]       hi_len,
  output logic      [31:0]       n_pulses
);
  // ----------------------------------------
  // Pulses at 25 MHz: 4 cycles high, 4 low
  // ----------------------------------------
  logic [31:0] cnt;
  initial begin
    TS_PIN = '0;
    cnt = '0;
    hi_len = '0;
    n_pulses = '0;
  end
  task automatic pulse(input logic [NUM_TS-1:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge CLOCK);
      TS_PIN <= TS_PIN | m;
      repeat (4) @(posedge CLOCK);
      TS_PIN <= TS_PIN & ~m;
      repeat (3) @(posedge CLOCK);
    end
  endtask
  always @(posedge CLOCK) begin
    if (TRIG_OUT) begin
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      hi_len <= cnt;
      n_pulses <= n_pulses + 1;
      cnt <= '0;
    end
  end
endmodule

// *** bench/ptp_evt_ctl_tb.sv ***
// Testbench of the trigger and timestamp control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("Error %s expected %h seen %h", n, e, g); end end
module ptp_evt_ctl_tb
  import ptp_evt_pkg::*;
;
  logic              CLOCK = 0;
  logic              RST_N = 0;
  logic              PSEL = 0;
  logic              PENABLE = 0;
  logic              PWRITE = 0;
  logic [11:0]       PADDR = '0;
  logic [31:0]       PWDATA = '0;
  logic [31:0]       TRIG_TARGET = 32'h1000_0000;
  logic [31:0]       PRDATA, TRIG_NEXT, rd, hi_len, n_pulses, n;
  logic              PREADY, PSLVERR, TRIG_OUT, IRQ;
  logic [NUM_TS-1:0] TS_PIN;
  int                n_errors = 0;
  int                num_checks = 0;
  always #2.5 CLOCK = ~CLOCK;
  ptp_evt_ctl #(.NTRIG(NUM_TRIG)) dut (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TS_PIN(TS_PIN), .TRIG_TARGET(TRIG_TARGET), .TRIG_NEXT(TRIG_NEXT), .TRIG_OUT(TRIG_OUT), .IRQ(IRQ));
  ts_pin_model pins (.CLOCK(CLOCK), .TRIG_OUT(TRIG_OUT), .TS_PIN(TS_PIN), .hi_len(hi_len), .n_pulses(n_pulses));
  // ----------------------------------------
  // Bus and helper tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rst();
    @(posedge CLOCK);
    RST_N <= 1'b0;
    repeat (16) @(posedge CLOCK);
    RST_N <= 1'b1;
  endtask
  // Read data is taken at the edge where PREADY is seen high; one idle edge follows
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge CLOCK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge CLOCK);
      if (PREADY === 1'b1) break;
    end
    if (k == 50) begin
      n_errors++;
      end_of_test();
    end
    rd = PRDATA;
    {PSEL, PENABLE} <= 2'b00;
    @(posedge CLOCK);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(s, e, rd)
  endtask
  task automatic trig(input logic [31:0] mode);
    int k;
    n = n_pulses;
    wr(OFF_MODE_CTL, mode);
    for (k = 0; k < 2000 && n_pulses == n; k++) @(posedge CLOCK);
    if (k == 2000) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic ts_stat(input logic [31:0] idx, input logic [4:0] e, input logic [7:0] c, input string s);
    wr(OFF_UNIT_INDEX, idx);
    rdc(s, OFF_TS_STATUS, {11'h000, e, 8'h00, c});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc("loop", OFF_CASCADE_LOOP, RST_CASCADE_LOOP);
    rdc("width", OFF_PULSE_WIDTH, {8'h00, RST_PPS_HIGH, RST_PULSE_WIDTH});
    rdc("status", OFF_TS_STATUS, 32'h0000_0000);
    rdc("unmapped", 12'h7FC, 32'h0000_0000);
    `CHK("slverr", 1'b0, PSLVERR)
  endtask
  task automatic t_trigger();
    for (int i = 0; i < NUM_TRIG; i++) begin
      wr(OFF_UNIT_INDEX, 32'(i));
      wr(OFF_CASCADE_LOOP, 32'h0000_0320 + 32'(i));
    end
    for (int i = 0; i < NUM_TRIG; i++) begin
      wr(OFF_UNIT_INDEX, 32'(i));
      rdc("loop", OFF_CASCADE_LOOP, 32'h0000_0320 + 32'(i));
    end
    wr(OFF_PULSE_WIDTH, 32'h0000_000A);
    trig(32'h0000_0005);
    `CHK("next", TRIG_TARGET + 32'h0000_0323, TRIG_NEXT)
    `CHK("pulse", 32'h0000_0010, hi_len)
    wr(OFF_PULSE_WIDTH, 32'h0000_0001);
    trig(32'h0000_0001);
    `CHK("next", TRIG_TARGET, TRIG_NEXT)
    `CHK("pulse", 32'h0000_0002, hi_len)
    `CHK("irq", 1'b0, IRQ)
    wr(OFF_IRQ_MASK, 32'h0000_0004);
    `CHK("irq", 1'b1, IRQ)
    wr(OFF_IRQ_STATUS, 32'h0000_0004);
    `CHK("irq", 1'b0, IRQ)
  endtask
  task automatic t_edges();
    wr(OFF_UNIT_INDEX, 32'h0000_0000);
    wr(OFF_TS_STATUS, 32'h0000_0080);
    pins.pulse(2'b01, 3);
    ts_stat(32'h0000_0000, 5'h06, 8'h80, "rise count");
    rdc("polarity", OFF_TS_SAMPLE, 32'h4000_0000);
    wr(OFF_TS_STATUS, 32'h0000_0040);
    pins.pulse(2'b01, 2);
    ts_stat(32'h0000_0000, 5'h04, 8'h40, "fall count");
    rdc("polarity", OFF_TS_SAMPLE, 32'h0000_0000);
    wr(OFF_TS_STATUS, 32'h0000_00C0);
    pins.pulse(2'b01, 7);
    ts_stat(32'h0000_0000, 5'h1C, 8'hC0, "count 14");
    pins.pulse(2'b01, 1);
    ts_stat(32'h0000_0000, 5'h1F, 8'hC0, "overflow");
    wr(OFF_IRQ_MASK, 32'h0000_0002);
    `CHK("irq", 1'b1, IRQ)
    wr(OFF_IRQ_STATUS, 32'h0000_0002);
    `CHK("irq", 1'b0, IRQ)
    rdc("irq status", OFF_IRQ_STATUS, 32'h0000_0001);
  endtask
  task automatic t_cascade();
    wr(OFF_MODE_CTL, 32'h0000_0004);
    wr(OFF_TS_STATUS, 32'h0000_0081);
    wr(OFF_UNIT_INDEX, 32'h0000_0100);
    wr(OFF_TS_STATUS, 32'h0000_00A1);
    pins.pulse(2'b10, 2);
    ts_stat(32'h0000_0100, 5'h00, 8'hA1, "tail idle");
    pins.pulse(2'b01, 16);
    ts_stat(32'h0000_0000, 5'h1E, 8'h81, "head full");
    pins.pulse(2'b10, 16);
    ts_stat(32'h0000_0100, 5'h1F, 8'hA1, "tail full");
  endtask
  task automatic t_pps();
    wr(OFF_MODE_CTL, 32'h0000_0000);
    wr(OFF_PULSE_WIDTH, 32'h0001_0002);
    rdc("pps", OFF_PULSE_WIDTH, 32'h0001_0002);
    wr(OFF_MODE_CTL, 32'h0000_0003);
    // Width alone would end after 4 cycles; the long pulse is cut by reset
    repeat (20) @(posedge CLOCK);
    `CHK("pps out", 1'b1, TRIG_OUT)
    rst();
    rdc("width", OFF_PULSE_WIDTH, 32'h0000_0000);
  endtask
  initial begin
    rst();
    t_reset();
    t_trigger();
    t_edges();
    t_cascade();
    t_pps();
    end_of_test();
  end
endmodule
